//--- src/insn_classify.sv
// combinational classifier: format and operand roles from the opcode bits
module insn_classify (
  // instruction word
  input  wire logic [15:0]            word_in,
  // classification
  output insn_decode_pkg::fmt_t      fmt_out,
  output insn_decode_pkg::role_t     src_role_out,
  output insn_decode_pkg::role_t     dst_role_out,
  output logic                       src2_is_n_out
);

  logic [3:0] hi;
  logic [3:0] lo;
  logic [3:0] mid;

  assign hi  = word_in[15:12];
  assign mid = word_in[11:8];
  assign lo  = word_in[3:0];

  // roles follow opcode bits since field positions are shared
  always_comb begin
    fmt_out       = insn_decode_pkg::FMT_BAD;
    src_role_out  = insn_decode_pkg::ROLE_NONE;
    dst_role_out  = insn_decode_pkg::ROLE_NONE;
    src2_is_n_out = 1'b0;
    case (hi)
      4'h0: begin
        if (word_in[7:4] == 4'h0 && (lo == 4'h8 || lo == 4'h9 || lo == 4'hb) && mid == 4'h0) begin
          fmt_out = insn_decode_pkg::FMT_ZERO;
        end else if (lo == 4'h2 || lo == 4'ha || lo == 4'h9) begin
          fmt_out      = insn_decode_pkg::FMT_N;
          src_role_out = (lo == 4'h9) ? insn_decode_pkg::ROLE_NONE : insn_decode_pkg::ROLE_SYSREG;
          dst_role_out = insn_decode_pkg::ROLE_DIRECT;
        end else if (lo == 4'h3) begin
          fmt_out      = insn_decode_pkg::FMT_M;
          src_role_out = insn_decode_pkg::ROLE_PC_REL;
        end else if (lo == 4'hf) begin
          fmt_out       = insn_decode_pkg::FMT_NM;
          src_role_out  = insn_decode_pkg::ROLE_POSTINC;
          dst_role_out  = insn_decode_pkg::ROLE_ACCUM;
          src2_is_n_out = 1'b1;
        end else if (lo == 4'h4 || lo == 4'h5 || lo == 4'h6) begin
          fmt_out      = insn_decode_pkg::FMT_NM;
          src_role_out = insn_decode_pkg::ROLE_DIRECT;
          dst_role_out = insn_decode_pkg::ROLE_IDX_ZERO;
        end else begin
          fmt_out      = insn_decode_pkg::FMT_NM;
          src_role_out = insn_decode_pkg::ROLE_IDX_ZERO;
          dst_role_out = insn_decode_pkg::ROLE_DIRECT;
        end
      end
      4'h1: begin
        fmt_out      = insn_decode_pkg::FMT_NMD;
        src_role_out = insn_decode_pkg::ROLE_DIRECT;
        dst_role_out = insn_decode_pkg::ROLE_DISP_REG;
      end
      4'h2: begin
        fmt_out      = insn_decode_pkg::FMT_NM;
        src_role_out = insn_decode_pkg::ROLE_DIRECT;
        dst_role_out = (lo[3:2] == 2'b01) ? insn_decode_pkg::ROLE_PREDEC :
                       (lo[3:2] == 2'b00) ? insn_decode_pkg::ROLE_INDIRECT : insn_decode_pkg::ROLE_DIRECT;
      end
      4'h3: begin
        fmt_out      = insn_decode_pkg::FMT_NM;
        src_role_out = insn_decode_pkg::ROLE_DIRECT;
        dst_role_out = insn_decode_pkg::ROLE_DIRECT;
      end
      4'h4: begin
        if (lo == 4'hf) begin
          fmt_out       = insn_decode_pkg::FMT_NM;
          src_role_out  = insn_decode_pkg::ROLE_POSTINC;
          dst_role_out  = insn_decode_pkg::ROLE_ACCUM;
          src2_is_n_out = 1'b1;
        end else if (lo == 4'h3 || lo == 4'h2) begin
          fmt_out      = insn_decode_pkg::FMT_N;
          src_role_out = insn_decode_pkg::ROLE_SYSREG;
          dst_role_out = insn_decode_pkg::ROLE_PREDEC;
        end else if (lo == 4'he || lo == 4'ha) begin
          fmt_out      = insn_decode_pkg::FMT_M;
          src_role_out = insn_decode_pkg::ROLE_DIRECT;
          dst_role_out = insn_decode_pkg::ROLE_SYSREG;
        end else if (lo == 4'h7 || lo == 4'h6) begin
          fmt_out      = insn_decode_pkg::FMT_M;
          src_role_out = insn_decode_pkg::ROLE_POSTINC;
          dst_role_out = insn_decode_pkg::ROLE_SYSREG;
        end else if (lo == 4'hb) begin
          fmt_out      = insn_decode_pkg::FMT_M;
          src_role_out = insn_decode_pkg::ROLE_INDIRECT;
        end else if (lo == 4'hc || lo == 4'hd) begin
          fmt_out      = insn_decode_pkg::FMT_NM;
          src_role_out = insn_decode_pkg::ROLE_DIRECT;
          dst_role_out = insn_decode_pkg::ROLE_DIRECT;
        end else begin
          fmt_out      = insn_decode_pkg::FMT_N;
          dst_role_out = insn_decode_pkg::ROLE_DIRECT;
        end
      end
      4'h5: begin
        fmt_out      = insn_decode_pkg::FMT_NMD;
        src_role_out = insn_decode_pkg::ROLE_DISP_REG;
        dst_role_out = insn_decode_pkg::ROLE_DIRECT;
      end
      4'h6: begin
        fmt_out      = insn_decode_pkg::FMT_NM;
        src_role_out = (lo[3:2] == 2'b01) ? insn_decode_pkg::ROLE_POSTINC :
                       (lo[3:2] == 2'b00) ? insn_decode_pkg::ROLE_INDIRECT : insn_decode_pkg::ROLE_DIRECT;
        dst_role_out = insn_decode_pkg::ROLE_DIRECT;
      end
      4'h7: begin
        fmt_out      = insn_decode_pkg::FMT_NI;
        src_role_out = insn_decode_pkg::ROLE_IMM;
        dst_role_out = insn_decode_pkg::ROLE_DIRECT;
      end
      4'h8: begin
        if (mid == 4'h0 || mid == 4'h1) begin
          fmt_out      = (mid == 4'h0) ? insn_decode_pkg::FMT_ND4 : insn_decode_pkg::FMT_MD;
          src_role_out = (mid == 4'h0) ? insn_decode_pkg::ROLE_REG_ZERO : insn_decode_pkg::ROLE_DISP_REG;
          dst_role_out = (mid == 4'h0) ? insn_decode_pkg::ROLE_DISP_REG : insn_decode_pkg::ROLE_REG_ZERO;
        end else if (mid == 4'h8) begin
          fmt_out      = insn_decode_pkg::FMT_I;
          src_role_out = insn_decode_pkg::ROLE_IMM;
          dst_role_out = insn_decode_pkg::ROLE_REG_ZERO;
        end else begin
          fmt_out      = insn_decode_pkg::FMT_D;
          src_role_out = insn_decode_pkg::ROLE_PC_REL;
        end
      end
      4'h9, 4'hd: begin
        fmt_out      = insn_decode_pkg::FMT_ND8;
        src_role_out = insn_decode_pkg::ROLE_DISP_PC;
        dst_role_out = insn_decode_pkg::ROLE_DIRECT;
      end
      4'ha, 4'hb: begin
        fmt_out      = insn_decode_pkg::FMT_D12;
        src_role_out = insn_decode_pkg::ROLE_PC_REL;
      end
      4'hc: begin
        if (mid == 4'h3) begin
          fmt_out      = insn_decode_pkg::FMT_I;
          src_role_out = insn_decode_pkg::ROLE_TRAP;
        end else if (mid == 4'h7) begin
          fmt_out      = insn_decode_pkg::FMT_D;
          src_role_out = insn_decode_pkg::ROLE_DISP_PC;
          dst_role_out = insn_decode_pkg::ROLE_REG_ZERO;
        end else if (mid[3]) begin
          fmt_out      = insn_decode_pkg::FMT_I;
          src_role_out = insn_decode_pkg::ROLE_IMM;
          dst_role_out = mid[2] ? insn_decode_pkg::ROLE_IDX_GBR : insn_decode_pkg::ROLE_REG_ZERO;
        end else begin
          fmt_out      = insn_decode_pkg::FMT_D;
          src_role_out = mid[2] ? insn_decode_pkg::ROLE_DISP_GBR : insn_decode_pkg::ROLE_REG_ZERO;
          dst_role_out = mid[2] ? insn_decode_pkg::ROLE_REG_ZERO : insn_decode_pkg::ROLE_DISP_GBR;
        end
      end
      4'he: begin
        fmt_out      = insn_decode_pkg::FMT_NI;
        src_role_out = insn_decode_pkg::ROLE_IMM;
        dst_role_out = insn_decode_pkg::ROLE_DIRECT;
      end
      default: begin
        fmt_out = insn_decode_pkg::FMT_BAD;
      end
    endcase
  end

endmodule : insn_classify

//--- src/insn_decode_pkg.sv
// package: field layout, formats and operand roles for the 16-bit instruction decoder
package insn_decode_pkg;

  localparam int WORD_W    = 16;
  localparam int OP_HI_MSB = 15;
  localparam int OP_HI_LSB = 12;
  localparam int DST_MSB   = 11;
  localparam int DST_LSB   = 8;
  localparam int SRC_MSB   = 7;
  localparam int SRC_LSB   = 4;
  localparam int IMM_MSB   = 7;
  localparam int IMM_LSB   = 0;
  localparam int D4_MSB    = 3;
  localparam int D12_MSB   = 11;

  typedef enum logic [3:0] {
    FMT_ZERO, FMT_N, FMT_M, FMT_NM, FMT_MD, FMT_ND4,
    FMT_NMD, FMT_D, FMT_D12, FMT_ND8, FMT_I, FMT_NI, FMT_BAD
  } fmt_t;

  // operand addressing roles
  typedef enum logic [3:0] {
    ROLE_NONE, ROLE_DIRECT, ROLE_INDIRECT, ROLE_POSTINC, ROLE_PREDEC,
    ROLE_IDX_ZERO, ROLE_DISP_REG, ROLE_DISP_GBR, ROLE_DISP_PC, ROLE_PC_REL,
    ROLE_IMM, ROLE_IDX_GBR, ROLE_SYSREG, ROLE_ACCUM, ROLE_TRAP, ROLE_REG_ZERO
  } role_t;

  typedef struct packed {
    logic        valid;
    fmt_t        fmt;
    logic [15:0] opcode;      // opcode bits only, field bits zeroed
    logic [3:0]  dest_reg;
    logic [3:0]  src_reg;
    logic        dest_used;
    logic        src_used;
    logic        src2_is_n;   // field 11:8 is a second source
    logic [7:0]  imm;
    logic        imm_used;
    logic [11:0] disp;
    logic        disp_used;
    role_t       src_role;
    role_t       dst_role;
  } dec_t;

  localparam logic [15:0] OPC_RESET = 16'h0000;

endpackage : insn_decode_pkg

//--- src/insn_field_decoder.sv
// top: splits a 16-bit instruction word into fields and registers the result
// Notes on behaviour
// - every word is 16 bits (15..0) and the operand-free format extracts no register or immediate field.
// - five field kinds are separated: opcode, source index, destination index, immediate and displacement.
// - the addressing role of each field is chosen from the opcode bits.
// - the single-source format takes bits 11..8 as source index for control loads, indirect jump and far branch.
// - the single-destination format takes bits 11..8 as destination, direct or pre-decrement indirect.
// - post-increment source serves both control register loads and moves into a general register.
// - the two-register format has destination in 11..8 and source in 7..4 with direct, indirect, predec, indexed.
// - multiply-accumulate treats bits 11..8 as a second post-increment source; results go to the accumulator.
// - the 8-bit immediate format uses the low eight bits for register zero, indexed global base or trap vector.
module insn_field_decoder (
  // clock and reset
  input  wire logic                  CLK_IN,
  input  wire logic                  RST_IN,
  // fetch side
  input  wire logic                  WORD_VALID_IN,
  input  wire logic [15:0]           WORD_IN,
  // decoded result
  output insn_decode_pkg::dec_t      DEC_OUT
);

  insn_decode_pkg::fmt_t  fmt;
  insn_decode_pkg::role_t src_role;
  insn_decode_pkg::role_t dst_role;
  logic                   src2_is_n;
  insn_decode_pkg::dec_t  dec_reg;
  insn_decode_pkg::dec_t  dec_next;

  // opcode-driven roles
  insn_classify u_classify (
    .word_in       (WORD_IN),
    .fmt_out       (fmt),
    .src_role_out  (src_role),
    .dst_role_out  (dst_role),
    .src2_is_n_out (src2_is_n)
  );

  // field extraction, same cycle as the word
  always_comb begin
    dec_next           = '0;
    dec_next.valid     = WORD_VALID_IN;
    dec_next.fmt       = fmt;
    dec_next.src_role  = src_role;
    dec_next.dst_role  = dst_role;
    dec_next.src2_is_n = src2_is_n;
    dec_next.opcode    = WORD_IN;
    case (fmt)
      insn_decode_pkg::FMT_ZERO: begin
        dec_next.opcode = WORD_IN;
      end
      insn_decode_pkg::FMT_N: begin
        dec_next.dest_reg  = WORD_IN[insn_decode_pkg::DST_MSB:insn_decode_pkg::DST_LSB];
        dec_next.dest_used = 1'b1;
        dec_next.opcode[11:8] = 4'h0;
      end
      insn_decode_pkg::FMT_M: begin
        dec_next.src_reg  = WORD_IN[insn_decode_pkg::DST_MSB:insn_decode_pkg::DST_LSB];
        dec_next.src_used = 1'b1;
        dec_next.opcode[11:8] = 4'h0;
      end
      insn_decode_pkg::FMT_NM: begin
        dec_next.src_reg   = WORD_IN[insn_decode_pkg::SRC_MSB:insn_decode_pkg::SRC_LSB];
        dec_next.dest_reg  = WORD_IN[insn_decode_pkg::DST_MSB:insn_decode_pkg::DST_LSB];
        dec_next.src_used  = 1'b1;
        dec_next.dest_used = 1'b1; // flagged by src2_is_n
        dec_next.opcode[11:4] = 8'h00;
      end
      insn_decode_pkg::FMT_MD: begin
        dec_next.src_reg   = WORD_IN[insn_decode_pkg::SRC_MSB:insn_decode_pkg::SRC_LSB];
        dec_next.src_used  = 1'b1;
        dec_next.disp      = {8'h00, WORD_IN[insn_decode_pkg::D4_MSB:0]};
        dec_next.disp_used = 1'b1;
        dec_next.opcode[7:0] = 8'h00;
      end
      insn_decode_pkg::FMT_ND4: begin
        dec_next.dest_reg  = WORD_IN[insn_decode_pkg::SRC_MSB:insn_decode_pkg::SRC_LSB];
        dec_next.dest_used = 1'b1;
        dec_next.disp      = {8'h00, WORD_IN[insn_decode_pkg::D4_MSB:0]};
        dec_next.disp_used = 1'b1;
        dec_next.opcode[7:0] = 8'h00;
      end
      insn_decode_pkg::FMT_NMD: begin
        dec_next.dest_reg  = WORD_IN[insn_decode_pkg::DST_MSB:insn_decode_pkg::DST_LSB];
        dec_next.src_reg   = WORD_IN[insn_decode_pkg::SRC_MSB:insn_decode_pkg::SRC_LSB];
        dec_next.dest_used = 1'b1;
        dec_next.src_used  = 1'b1;
        dec_next.disp      = {8'h00, WORD_IN[insn_decode_pkg::D4_MSB:0]};
        dec_next.disp_used = 1'b1;
        dec_next.opcode[11:0] = 12'h000;
      end
      insn_decode_pkg::FMT_D: begin
        dec_next.disp      = {4'h0, WORD_IN[insn_decode_pkg::IMM_MSB:insn_decode_pkg::IMM_LSB]};
        dec_next.disp_used = 1'b1;
        dec_next.opcode[7:0] = 8'h00;
      end
      insn_decode_pkg::FMT_D12: begin
        dec_next.disp      = WORD_IN[insn_decode_pkg::D12_MSB:0];
        dec_next.disp_used = 1'b1;
        dec_next.opcode[11:0] = 12'h000;
      end
      insn_decode_pkg::FMT_ND8: begin
        dec_next.dest_reg  = WORD_IN[insn_decode_pkg::DST_MSB:insn_decode_pkg::DST_LSB];
        dec_next.dest_used = 1'b1;
        dec_next.disp      = {4'h0, WORD_IN[insn_decode_pkg::IMM_MSB:insn_decode_pkg::IMM_LSB]};
        dec_next.disp_used = 1'b1;
        dec_next.opcode[11:0] = 12'h000;
      end
      insn_decode_pkg::FMT_I: begin
        dec_next.imm      = WORD_IN[insn_decode_pkg::IMM_MSB:insn_decode_pkg::IMM_LSB];
        dec_next.imm_used = 1'b1;
        dec_next.opcode[7:0] = 8'h00;
      end
      insn_decode_pkg::FMT_NI: begin
        dec_next.dest_reg  = WORD_IN[insn_decode_pkg::DST_MSB:insn_decode_pkg::DST_LSB];
        dec_next.dest_used = 1'b1;
        dec_next.imm       = WORD_IN[insn_decode_pkg::IMM_MSB:insn_decode_pkg::IMM_LSB];
        dec_next.imm_used  = 1'b1;
        dec_next.opcode[11:0] = 12'h000;
      end
      default: begin
        dec_next.opcode = WORD_IN; // undefined words pass as opcode only
      end
    endcase
    if (!WORD_VALID_IN) begin
      dec_next = '0; // bubbles carry no stale fields downstream
    end
  end

  // single pipeline register, the only state held
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      dec_reg <= '0;
    end else begin
      dec_reg <= dec_next;
    end
  end

  assign DEC_OUT = dec_reg;

  // checks
  chk_zero_no_fields: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    WORD_VALID_IN && fmt == insn_decode_pkg::FMT_ZERO |=> !DEC_OUT.dest_used && !DEC_OUT.src_used && !DEC_OUT.imm_used)
    else $error("operand-free word produced a field");
  chk_pipe_latency: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    WORD_VALID_IN |=> DEC_OUT.valid && DEC_OUT.fmt == $past(fmt))
    else $error("decode not presented one cycle later");
  chk_nm_fields: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    WORD_VALID_IN && fmt == insn_decode_pkg::FMT_NM |=>
      DEC_OUT.dest_reg == $past(WORD_IN[11:8]) && DEC_OUT.src_reg == $past(WORD_IN[7:4]))
    else $error("two-register fields wrong");
  chk_m_source: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    WORD_VALID_IN && fmt == insn_decode_pkg::FMT_M |=> DEC_OUT.src_used && DEC_OUT.src_reg == $past(WORD_IN[11:8]))
    else $error("single-source index wrong");
  chk_n_dest: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    WORD_VALID_IN && fmt == insn_decode_pkg::FMT_N |=> DEC_OUT.dest_used && !DEC_OUT.src_used)
    else $error("single-destination fields wrong");
  chk_mac_src2: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    WORD_VALID_IN && WORD_IN[15:12] == 4'h4 && WORD_IN[3:0] == 4'hf |=>
      DEC_OUT.src2_is_n && DEC_OUT.dst_role == insn_decode_pkg::ROLE_ACCUM)
    else $error("multiply-accumulate not decoded as two sources");
  chk_imm_low: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    WORD_VALID_IN && fmt == insn_decode_pkg::FMT_I |=> DEC_OUT.imm == $past(WORD_IN[7:0]))
    else $error("immediate not low byte");
  chk_postinc_load: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    WORD_VALID_IN && WORD_IN[15:12] == 4'h6 && WORD_IN[3:2] == 2'b01 |=>
      DEC_OUT.src_role == insn_decode_pkg::ROLE_POSTINC)
    else $error("post-increment move source missing");
  chk_role_bubble: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    !WORD_VALID_IN |=> DEC_OUT == '0)
    else $error("bubble carried fields");

  cov_mac: cover property (@(posedge CLK_IN) disable iff (RST_IN) DEC_OUT.src2_is_n);
  cov_trap: cover property (@(posedge CLK_IN) disable iff (RST_IN) DEC_OUT.src_role == insn_decode_pkg::ROLE_TRAP);
  cov_d12: cover property (@(posedge CLK_IN) disable iff (RST_IN) DEC_OUT.fmt == insn_decode_pkg::FMT_D12);

endmodule : insn_field_decoder

//--- tb/fetch_model.sv
// fetch-stage model: hands one instruction word a cycle to the decoder
module fetch_model (
  // clock
  input  wire logic        clk_in,
  // instruction word toward the decoder
  output logic             word_valid_out,
  output logic [15:0]      word_out
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] last_word;

  // quiet until the bench asks for a word
  initial begin
    word_valid_out = 1'b0;
    word_out       = 16'h0000;
    last_word      = 16'h0000;
  end

  // word goes out after the falling edge and is taken at the next rising edge
  task automatic give(input logic [15:0] w);
    @(negedge clk_in);
    word_valid_out = 1'b1;
    word_out       = w;
    last_word      = w;
  endtask : give

  // no word: lines show the inverse so a stale word never looks fresh
  task automatic idle();
    @(negedge clk_in);
    word_valid_out = 1'b0;
    word_out       = ~last_word;
  endtask : idle
endmodule : fetch_model

//--- tb/test_insn_field_decoder.sv
// self-checking bench for the instruction field decoder
module test_insn_field_decoder;
  timeunit 1ns;
  timeprecision 1ps;

  logic                  clk;
  logic                  rst;
  logic                  word_valid;
  logic [15:0]           word;
  insn_decode_pkg::dec_t dec;
  int                    err_total;
  int                    n_tests;

  // 100 MHz core clock
  initial clk = 1'b0;
  always #5 clk = ~clk;

  fetch_model u_fetch_model (.clk_in(clk), .word_valid_out(word_valid), .word_out(word));

  insn_field_decoder u_insn_field_decoder (
    .CLK_IN       (clk),
    .RST_IN       (rst),
    .WORD_VALID_IN(word_valid),
    .WORD_IN      (word),
    .DEC_OUT      (dec)
  );

  // one comparison, counted and reported on mismatch
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // judges the registered decode of word w; fl = {src2 expected, src role cared, dst role cared}
  task automatic judge(input logic [15:0] w, input insn_decode_pkg::fmt_t f, input insn_decode_pkg::role_t s,
                       input insn_decode_pkg::role_t d, input logic [2:0] fl);
    logic [15:0] keep;
    keep = 16'hffff;
    chk("valid", 64'(dec.valid), 64'h1);
    chk("fmt", 64'(dec.fmt), 64'(f));
    chk("src2_is_n", 64'(dec.src2_is_n), 64'(fl[2]));
    if (fl[1]) chk("src_role", 64'(dec.src_role), 64'(s));
    if (fl[0]) chk("dst_role", 64'(dec.dst_role), 64'(d));
    // field bits are masked out of the opcode per format
    case (f)
      insn_decode_pkg::FMT_N: begin
        keep = 16'hf0ff;
        chk("dest_reg", 64'(dec.dest_reg), 64'(w[11:8]));
        chk("used", 64'({dec.dest_used, dec.src_used}), 64'h2);
      end
      insn_decode_pkg::FMT_M: begin
        keep = 16'hf0ff;
        chk("src_reg", 64'(dec.src_reg), 64'(w[11:8]));
        chk("used", 64'({dec.dest_used, dec.src_used}), 64'h1);
      end
      insn_decode_pkg::FMT_NM: begin
        keep = 16'hf00f;
        chk("dest_reg", 64'(dec.dest_reg), 64'(w[11:8]));
        chk("src_reg", 64'(dec.src_reg), 64'(w[7:4]));
        chk("used", 64'({dec.dest_used, dec.src_used}), 64'h3);
      end
      insn_decode_pkg::FMT_MD: begin
        keep = 16'hff00;
        chk("src_reg", 64'(dec.src_reg), 64'(w[7:4]));
        chk("disp", 64'({dec.disp_used, dec.disp}), 64'({1'b1, 8'h00, w[3:0]}));
      end
      insn_decode_pkg::FMT_ND4: begin
        keep = 16'hff00;
        chk("dest_reg", 64'(dec.dest_reg), 64'(w[7:4]));
        chk("disp", 64'({dec.disp_used, dec.disp}), 64'({1'b1, 8'h00, w[3:0]}));
      end
      insn_decode_pkg::FMT_NMD: begin
        keep = 16'hf000;
        chk("dest_reg", 64'(dec.dest_reg), 64'(w[11:8]));
        chk("src_reg", 64'(dec.src_reg), 64'(w[7:4]));
        chk("disp", 64'({dec.disp_used, dec.disp}), 64'({1'b1, 8'h00, w[3:0]}));
      end
      insn_decode_pkg::FMT_D: begin
        keep = 16'hff00;
        chk("disp", 64'({dec.disp_used, dec.disp}), 64'({1'b1, 4'h0, w[7:0]}));
      end
      insn_decode_pkg::FMT_ND8: begin
        keep = 16'hf000;
        chk("dest_reg", 64'(dec.dest_reg), 64'(w[11:8]));
        chk("disp", 64'({dec.disp_used, dec.disp}), 64'({1'b1, 4'h0, w[7:0]}));
      end
      insn_decode_pkg::FMT_NI: begin
        keep = 16'hf000;
        chk("dest_reg", 64'(dec.dest_reg), 64'(w[11:8]));
        chk("imm", 64'({dec.imm_used, dec.imm}), 64'({1'b1, w[7:0]}));
      end
      insn_decode_pkg::FMT_I: begin
        keep = 16'hff00;
        chk("imm", 64'({dec.imm_used, dec.imm}), 64'({1'b1, w[7:0]}));
      end
      insn_decode_pkg::FMT_D12: begin
        keep = 16'hf000;
        chk("disp", 64'({dec.disp_used, dec.disp}), 64'({1'b1, w[11:0]}));
      end
      default: chk("used", 64'({dec.dest_used, dec.src_used, dec.imm_used, dec.disp_used}), 64'h0);
    endcase
    chk("opcode", 64'(dec.opcode), 64'(w & keep));
  endtask : judge

  // reset clears the output even with a word pending; idle cycles decode to zero
  task automatic t_reset();
    chk("dec", 64'(dec), 64'h0);
    u_fetch_model.give(16'h6ab6);
    @(negedge clk);
    chk("valid", 64'(dec.valid), 64'h1);
    rst = 1'b1;
    @(negedge clk);
    chk("dec", 64'(dec), 64'h0);
    rst = 1'b0;
    u_fetch_model.idle();
    chk("valid", 64'(dec.valid), 64'h1);
    u_fetch_model.idle();
    chk("dec", 64'(dec), 64'h0);
  endtask : t_reset

  // operand-free words, back to back
  task automatic t_zero();
    logic [15:0] w [2] = '{16'h0009, 16'h000b};
    u_fetch_model.give(w[0]);
    u_fetch_model.give(w[1]);
    judge(w[0], insn_decode_pkg::FMT_ZERO, insn_decode_pkg::ROLE_NONE, insn_decode_pkg::ROLE_NONE, 3'b011);
    u_fetch_model.idle();
    judge(w[1], insn_decode_pkg::FMT_ZERO, insn_decode_pkg::ROLE_NONE, insn_decode_pkg::ROLE_NONE, 3'b011);
  endtask : t_zero

  // destination-only words: direct and pre-decrement
  task automatic t_dest();
    logic [15:0] w [3] = '{16'h0529, 16'h0a0a, 16'h4c03};
    u_fetch_model.give(w[0]);
    u_fetch_model.give(w[1]);
    judge(w[0], insn_decode_pkg::FMT_N, insn_decode_pkg::ROLE_NONE, insn_decode_pkg::ROLE_DIRECT, 3'b001);
    u_fetch_model.give(w[2]);
    judge(w[1], insn_decode_pkg::FMT_N, insn_decode_pkg::ROLE_SYSREG, insn_decode_pkg::ROLE_DIRECT, 3'b011);
    u_fetch_model.idle();
    judge(w[2], insn_decode_pkg::FMT_N, insn_decode_pkg::ROLE_SYSREG, insn_decode_pkg::ROLE_PREDEC, 3'b011);
  endtask : t_dest

  // source-only words: control loads, indirect jump, far branch
  task automatic t_src();
    logic [15:0] w [4] = '{16'h4a0e, 16'h4b07, 16'h432b, 16'h0623};
    u_fetch_model.give(w[0]);
    u_fetch_model.give(w[1]);
    judge(w[0], insn_decode_pkg::FMT_M, insn_decode_pkg::ROLE_DIRECT, insn_decode_pkg::ROLE_SYSREG, 3'b011);
    u_fetch_model.give(w[2]);
    judge(w[1], insn_decode_pkg::FMT_M, insn_decode_pkg::ROLE_POSTINC, insn_decode_pkg::ROLE_SYSREG, 3'b011);
    u_fetch_model.give(w[3]);
    judge(w[2], insn_decode_pkg::FMT_M, insn_decode_pkg::ROLE_INDIRECT, insn_decode_pkg::ROLE_NONE, 3'b010);
    u_fetch_model.idle();
    judge(w[3], insn_decode_pkg::FMT_M, insn_decode_pkg::ROLE_PC_REL, insn_decode_pkg::ROLE_NONE, 3'b010);
  endtask : t_src

  // two-register words: same field positions, roles picked by opcode
  task automatic t_two_reg();
    logic [15:0] w [5] = '{16'h6ab6, 16'h2352, 16'h2cd6, 16'h0e76, 16'h4e5f};
    u_fetch_model.give(w[0]);
    u_fetch_model.give(w[1]);
    judge(w[0], insn_decode_pkg::FMT_NM, insn_decode_pkg::ROLE_POSTINC, insn_decode_pkg::ROLE_DIRECT, 3'b011);
    u_fetch_model.give(w[2]);
    judge(w[1], insn_decode_pkg::FMT_NM, insn_decode_pkg::ROLE_DIRECT, insn_decode_pkg::ROLE_INDIRECT, 3'b011);
    u_fetch_model.give(w[3]);
    judge(w[2], insn_decode_pkg::FMT_NM, insn_decode_pkg::ROLE_DIRECT, insn_decode_pkg::ROLE_PREDEC, 3'b011);
    u_fetch_model.give(w[4]);
    judge(w[3], insn_decode_pkg::FMT_NM, insn_decode_pkg::ROLE_DIRECT, insn_decode_pkg::ROLE_IDX_ZERO, 3'b011);
    u_fetch_model.idle();
    judge(w[4], insn_decode_pkg::FMT_NM, insn_decode_pkg::ROLE_POSTINC, insn_decode_pkg::ROLE_ACCUM, 3'b111);
  endtask : t_two_reg

  // immediate and long displacement words
  task automatic t_imm();
    logic [15:0] w [4] = '{16'hc9a5, 16'hcd5a, 16'hc3ff, 16'ha123};
    u_fetch_model.give(w[0]);
    u_fetch_model.give(w[1]);
    judge(w[0], insn_decode_pkg::FMT_I, insn_decode_pkg::ROLE_IMM, insn_decode_pkg::ROLE_REG_ZERO, 3'b011);
    u_fetch_model.give(w[2]);
    judge(w[1], insn_decode_pkg::FMT_I, insn_decode_pkg::ROLE_IMM, insn_decode_pkg::ROLE_IDX_GBR, 3'b011);
    u_fetch_model.give(w[3]);
    judge(w[2], insn_decode_pkg::FMT_I, insn_decode_pkg::ROLE_TRAP, insn_decode_pkg::ROLE_NONE, 3'b010);
    u_fetch_model.idle();
    judge(w[3], insn_decode_pkg::FMT_D12, insn_decode_pkg::ROLE_NONE, insn_decode_pkg::ROLE_NONE, 3'b000);
  endtask : t_imm

  // short displacement, register-immediate and undecodable words
  task automatic t_disp();
    logic [15:0] w [7] = '{16'h1abc, 16'h8152, 16'h8047, 16'hc512, 16'h9e34, 16'h7d80, 16'hf123};
    u_fetch_model.give(w[0]);
    u_fetch_model.give(w[1]);
    judge(w[0], insn_decode_pkg::FMT_NMD, insn_decode_pkg::ROLE_DIRECT, insn_decode_pkg::ROLE_DISP_REG, 3'b011);
    u_fetch_model.give(w[2]);
    judge(w[1], insn_decode_pkg::FMT_MD, insn_decode_pkg::ROLE_DISP_REG, insn_decode_pkg::ROLE_REG_ZERO, 3'b011);
    u_fetch_model.give(w[3]);
    judge(w[2], insn_decode_pkg::FMT_ND4, insn_decode_pkg::ROLE_REG_ZERO, insn_decode_pkg::ROLE_DISP_REG, 3'b011);
    u_fetch_model.give(w[4]);
    judge(w[3], insn_decode_pkg::FMT_D, insn_decode_pkg::ROLE_DISP_GBR, insn_decode_pkg::ROLE_REG_ZERO, 3'b011);
    u_fetch_model.give(w[5]);
    judge(w[4], insn_decode_pkg::FMT_ND8, insn_decode_pkg::ROLE_DISP_PC, insn_decode_pkg::ROLE_DIRECT, 3'b011);
    u_fetch_model.give(w[6]);
    judge(w[5], insn_decode_pkg::FMT_NI, insn_decode_pkg::ROLE_IMM, insn_decode_pkg::ROLE_DIRECT, 3'b011);
    u_fetch_model.idle();
    judge(w[6], insn_decode_pkg::FMT_BAD, insn_decode_pkg::ROLE_NONE, insn_decode_pkg::ROLE_NONE, 3'b011);
  endtask : t_disp

  // counts, verdict and end of run
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done

  // hang guard: the whole run is far shorter than this
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    $display("run did not finish in time");
    test_done();
  end

  // main sequence: reset held 8 cycles, then the scenarios
  initial begin
    err_total = 0;
    n_tests   = 0;
    rst       = 1'b1;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_reset();
    t_zero();
    t_dest();
    t_src();
    t_two_reg();
    t_imm();
    t_disp();
    test_done();
  end
endmodule : test_insn_field_decoder
